// file: cmrc_top.v
/*
 Clock mode and reset controller: gated idle wake, fast/slow clock switch,
 reset generation, register access over APB.
 Assumes a 200 MHz CLK_IN, an APB master on the same clock, and pins
 RST_PIN_N_IN and TB_SRC_IN that are asynchronous to CLK_IN.
*/
`timescale 1ns/1ps
`include "cmrc_defines.vh"

module cmrc_top
(
  input  wire        CLK_IN,
  input  wire        RESETN_IN,
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [11:0] PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output reg  [31:0] PRDATA_OUT,
  output reg         PREADY_OUT,
  output reg         PSLVERR_OUT,
  input  wire        RST_PIN_N_IN,
  input  wire        TB_SRC_IN,
  input  wire        WDT_IRQ_IN,
  input  wire        WDT_RST_REQ_IN,
  output reg         SYS_RESET_N_OUT,
  output reg  [15:0] START_VECTOR_OUT,
  output reg         HF_OSC_EN_OUT,
  output reg         LF_OSC_EN_OUT,
  output reg         CLK_SEL_SLOW_OUT,
  output reg         IDLE_GATED_OUT,
  output reg         TBT_IRQ_START_OUT,
  output reg         TRAP_IRQ_OUT,
  output reg         PRESCALER_CLR_OUT,
  output reg         WDT_ENABLE_OUT
);

  localparam ST_RUN  = 2'd0;
  localparam ST_IDLE = 2'd1;
  localparam ST_SYNC = 2'd2;

  reg  [7:0]  sys2_q;
  reg  [7:0]  tbc_q;
  reg         master_interrupt_enable_q;
  reg         time_base_irq_enable_q;
  reg  [7:0]  trap_q;
  reg  [15:0] fetch_addr_q;
  reg  [2:0]  event_q;
  reg  [1:0]  state_q;
  reg  [7:0]  rst_cnt_q;
  reg  [7:0]  ext_cnt_q;
  reg  [3:0]  sync_cnt_q;
  reg         tb_prev_q;
  reg         clk_slow_eff_q;
  reg         pin_rst_q;
  wire        pin_low;
  wire        tb_sync;
  wire        wr;
  wire        rd;
  wire        tb_fall;
  reg  [7:0]  new_sys2;
  reg         clk_rst_req;
  reg         trap_hit;

  function in_trap_area;
    input [15:0] a;
    input [7:0]  t;
    begin
      in_trap_area = (t[`CMRC_TRAP_SFRON] && a <= `CMRC_SFR_LAST) ||
                     (t[`CMRC_TRAP_RAM_TRAP_SELECT] && a >= `CMRC_RAM_FIRST && a <= `CMRC_RAM_LAST);
    end
  endfunction

  cmrc_sync u_pin_sync
  (
    .clk_in     (CLK_IN),
    .resetn_in  (RESETN_IN),
    .rst_val_in (1'b1),
    .d_in       (RST_PIN_N_IN),
    .q_out      (pin_low)
  );

  cmrc_sync u_tb_sync
  (
    .clk_in     (CLK_IN),
    .resetn_in  (RESETN_IN),
    .rst_val_in (1'b0),
    .d_in       (TB_SRC_IN),
    .q_out      (tb_sync)
  );

  assign wr      = PSEL_IN && PENABLE_IN && PWRITE_IN && !pin_rst_q;
  assign rd      = PSEL_IN && PENABLE_IN && !PWRITE_IN;
  assign tb_fall = tb_prev_q && !tb_sync;

  always @*
  begin
    new_sys2    = PWDATA_IN[7:0];
    // Compare new enables with the select value the same write leaves
    clk_rst_req = wr && (PADDR_IN == `CMRC_ADDR_SYS2) &&
                  ((!new_sys2[`CMRC_SYS2_XEN] && !new_sys2[`CMRC_SYS2_LOW_FREQ_OSC_ENABLE]) ||
                   (!new_sys2[`CMRC_SYS2_XEN] && !new_sys2[`CMRC_SYS2_SYSTEM_CLOCK_SELECT]) ||
                   (!new_sys2[`CMRC_SYS2_LOW_FREQ_OSC_ENABLE] && new_sys2[`CMRC_SYS2_SYSTEM_CLOCK_SELECT]));
    trap_hit    = wr && (PADDR_IN == `CMRC_ADDR_FETCH) &&
                  in_trap_area(PWDATA_IN[15:0], trap_q);
  end

  // Pin must stay low twelve fast periods before reset applies
  always @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ext_cnt_q <= 8'h00;
      pin_rst_q <= 1'b1;
    end
    else if (pin_low)
    begin
      if (ext_cnt_q < `CMRC_EXT_CYC - 1)
        ext_cnt_q <= ext_cnt_q + 8'h01;
      else
        pin_rst_q <= 1'b1;
    end
    else
    begin
      ext_cnt_q <= 8'h00;
      pin_rst_q <= 1'b0;
    end
  end

  // Malfunction reset: fixed window well under the 24-period limit
  // The counter starts loaded, so power-up gives one such pulse
  always @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      rst_cnt_q <= `CMRC_RST_LOAD;
    else if (clk_rst_req || WDT_RST_REQ_IN || (trap_hit && !trap_q[`CMRC_TRAP_TOINT]))
      rst_cnt_q <= `CMRC_RST_LOAD;
    else if (rst_cnt_q != 8'h00)
      rst_cnt_q <= rst_cnt_q - 8'h01;
  end

  always @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      sys2_q                    <= `CMRC_SYS2_RESET;
      tbc_q                     <= 8'h00;
      master_interrupt_enable_q <= 1'b0;
      time_base_irq_enable_q    <= 1'b0;
      trap_q                    <= `CMRC_TRAP_RESET;
      fetch_addr_q              <= 16'h0000;
      event_q                   <= 3'h0;
      state_q                   <= ST_RUN;
      clk_slow_eff_q            <= 1'b0;
      sync_cnt_q                <= 4'h0;
      tb_prev_q                 <= 1'b0;
      TBT_IRQ_START_OUT         <= 1'b0;
      TRAP_IRQ_OUT              <= 1'b0;
    end
    else if (pin_rst_q || rst_cnt_q != 8'h00)
    begin
      // Any reset returns to dual-clock fast mode
      sys2_q                    <= `CMRC_SYS2_RESET;
      master_interrupt_enable_q <= 1'b0;
      time_base_irq_enable_q    <= 1'b0;
      tbc_q                     <= 8'h00;
      trap_q                    <= `CMRC_TRAP_RESET;
      state_q                   <= ST_RUN;
      clk_slow_eff_q            <= 1'b0;
      sync_cnt_q                <= 4'h0;
      tb_prev_q                 <= tb_sync;
      TBT_IRQ_START_OUT         <= 1'b0;
      TRAP_IRQ_OUT              <= 1'b0;
    end
    else
    begin
      tb_prev_q         <= tb_sync;
      TBT_IRQ_START_OUT <= 1'b0;
      TRAP_IRQ_OUT      <= trap_hit && trap_q[`CMRC_TRAP_TOINT];
      if (wr && PADDR_IN == `CMRC_ADDR_SYS2)
      begin
        sys2_q <= PWDATA_IN[7:0];
        // Watchdog interrupt in the same cycle wins over idle entry
        if (WDT_IRQ_IN)
          sys2_q[`CMRC_SYS2_TIMING_GENERATOR_HALT] <= 1'b0;
      end
      if (wr && PADDR_IN == `CMRC_ADDR_TBC)
        tbc_q <= PWDATA_IN[7:0];
      if (wr && PADDR_IN == `CMRC_ADDR_IRQ)
      begin
        master_interrupt_enable_q <= PWDATA_IN[0];
        time_base_irq_enable_q    <= PWDATA_IN[1];
      end
      if (wr && PADDR_IN == `CMRC_ADDR_TRAP)
        trap_q <= PWDATA_IN[7:0];
      if (wr && PADDR_IN == `CMRC_ADDR_FETCH)
        fetch_addr_q <= PWDATA_IN[15:0];
      // Event flags: set wins over write-one-to-clear
      if (wr && PADDR_IN == `CMRC_ADDR_EVENT)
        event_q <= (event_q & ~PWDATA_IN[2:0]) | {trap_hit, 1'b0, 1'b0};
      else if (trap_hit)
        event_q[2] <= 1'b1;
      case (state_q)
        ST_RUN:
        begin
          if (sys2_q[`CMRC_SYS2_TIMING_GENERATOR_HALT] && !WDT_IRQ_IN)
            state_q <= ST_IDLE;
          else if (sys2_q[`CMRC_SYS2_TIMING_GENERATOR_HALT])
            sys2_q[`CMRC_SYS2_TIMING_GENERATOR_HALT] <= 1'b0;
          else if (sys2_q[`CMRC_SYS2_SYSTEM_CLOCK_SELECT])
            clk_slow_eff_q <= 1'b1;
          else if (clk_slow_eff_q)
          begin
            // Fast clock is not taken until four cycles have passed in ST_SYNC
            sync_cnt_q <= 4'h0;
            state_q    <= ST_SYNC;
          end
        end
        ST_IDLE:
        begin
          // Wake rides a resynchronised async edge, so it lags the source fall by the two synchroniser stages
          if (tb_fall)
          begin
            sys2_q[`CMRC_SYS2_TIMING_GENERATOR_HALT] <= 1'b0;
            state_q                   <= ST_RUN;
            event_q[0]                <= 1'b1;
            TBT_IRQ_START_OUT <= master_interrupt_enable_q && time_base_irq_enable_q &&
                                 tbc_q[`CMRC_TBC_TIME_BASE_ENABLE];
            // No interrupt: plain resume at the next instruction
          end
        end
        ST_SYNC:
        begin
          if (sys2_q[`CMRC_SYS2_SYSTEM_CLOCK_SELECT])
            state_q <= ST_RUN;
          else if (sync_cnt_q == `CMRC_SYNC_CYC - 1)
          begin
            clk_slow_eff_q <= 1'b0;
            event_q[1]     <= 1'b1;
            state_q        <= ST_RUN;
          end
          else
            sync_cnt_q <= sync_cnt_q + 4'h1;
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

  // Outputs registered; oscillator enables follow software
  always @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      SYS_RESET_N_OUT   <= 1'b0;
      START_VECTOR_OUT  <= `CMRC_RESET_VECTOR;
      HF_OSC_EN_OUT     <= 1'b1;
      LF_OSC_EN_OUT     <= 1'b1;
      CLK_SEL_SLOW_OUT  <= 1'b0;
      IDLE_GATED_OUT    <= 1'b0;
      PRESCALER_CLR_OUT <= 1'b1;
      WDT_ENABLE_OUT    <= 1'b1;
      PRDATA_OUT        <= 32'h0000_0000;
      PREADY_OUT        <= 1'b0;
      PSLVERR_OUT       <= 1'b0;
    end
    else
    begin
      SYS_RESET_N_OUT   <= !(pin_rst_q || rst_cnt_q != 8'h00);
      START_VECTOR_OUT  <= `CMRC_RESET_VECTOR;
      // Clock-reset case keeps both oscillators running
      HF_OSC_EN_OUT     <= sys2_q[`CMRC_SYS2_XEN] || rst_cnt_q != 8'h00;
      LF_OSC_EN_OUT     <= sys2_q[`CMRC_SYS2_LOW_FREQ_OSC_ENABLE] || rst_cnt_q != 8'h00;
      CLK_SEL_SLOW_OUT  <= clk_slow_eff_q;
      IDLE_GATED_OUT    <= (state_q == ST_IDLE);
      PRESCALER_CLR_OUT <= pin_rst_q || rst_cnt_q != 8'h00;
      if (pin_rst_q || rst_cnt_q != 8'h00)
        WDT_ENABLE_OUT <= 1'b1;
      PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
      PSLVERR_OUT <= 1'b0;
      if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
      begin
        if (PADDR_IN == `CMRC_ADDR_SYS2)
          PRDATA_OUT <= {24'h00_0000, sys2_q};
        else if (PADDR_IN == `CMRC_ADDR_TBC)
          PRDATA_OUT <= {24'h00_0000, tbc_q};
        else if (PADDR_IN == `CMRC_ADDR_IRQ)
          PRDATA_OUT <= {30'h0000_0000, time_base_irq_enable_q, master_interrupt_enable_q};
        else if (PADDR_IN == `CMRC_ADDR_TRAP)
          PRDATA_OUT <= {24'h00_0000, trap_q};
        else if (PADDR_IN == `CMRC_ADDR_STATUS)
          PRDATA_OUT <= {27'h000_0000, pin_rst_q, clk_slow_eff_q, state_q, !pin_low};
        else if (PADDR_IN == `CMRC_ADDR_FETCH)
          PRDATA_OUT <= {16'h0000, fetch_addr_q};
        else if (PADDR_IN == `CMRC_ADDR_EVENT)
          PRDATA_OUT <= {29'h0000_0000, event_q};
        else
          PRDATA_OUT <= 32'h0000_0000;
      end
      if (PSEL_IN && !PENABLE_IN)
        PSLVERR_OUT <= !(PADDR_IN == `CMRC_ADDR_SYS2 || PADDR_IN == `CMRC_ADDR_TBC ||
                         PADDR_IN == `CMRC_ADDR_IRQ || PADDR_IN == `CMRC_ADDR_TRAP ||
                         PADDR_IN == `CMRC_ADDR_STATUS || PADDR_IN == `CMRC_ADDR_FETCH ||
                         PADDR_IN == `CMRC_ADDR_EVENT);
      if (PREADY_OUT)
      begin
        PREADY_OUT  <= 1'b0;
        PSLVERR_OUT <= 1'b0;
      end
    end
  end

endmodule

// file: cmrc_defines.vh
/*
 Constants for the clock mode and reset controller: register offsets,
 field positions, reset values and timing counts.
 Assumes a 200 MHz system clock and word-aligned APB offsets.
*/
`ifndef CMRC_DEFINES_VH
`define CMRC_DEFINES_VH

`define CMRC_CLK_PERIOD_PS      32'd5000
`define CMRC_HF_PERIOD_PS       32'd62500
`define CMRC_HF_CYC             ((`CMRC_HF_PERIOD_PS + `CMRC_CLK_PERIOD_PS - 32'd1) / `CMRC_CLK_PERIOD_PS)
`define CMRC_RST_HF_PERIODS     32'd24
`define CMRC_EXT_HF_PERIODS     32'd12
`define CMRC_RST_CYC            (`CMRC_RST_HF_PERIODS * `CMRC_HF_PERIOD_PS / `CMRC_CLK_PERIOD_PS)
`define CMRC_EXT_CYC            ((`CMRC_EXT_HF_PERIODS * `CMRC_HF_PERIOD_PS + `CMRC_CLK_PERIOD_PS - 32'd1) / `CMRC_CLK_PERIOD_PS)
`define CMRC_SYNC_CYC           32'd4
`define CMRC_RST_LOAD           8'h5F

`define CMRC_ADDR_SYS2          12'h000
`define CMRC_ADDR_TBC           12'h004
`define CMRC_ADDR_IRQ           12'h008
`define CMRC_ADDR_TRAP          12'h00C
`define CMRC_ADDR_STATUS        12'h010
`define CMRC_ADDR_FETCH         12'h014
`define CMRC_ADDR_EVENT         12'h018

`define CMRC_SYS2_XEN           7
`define CMRC_SYS2_LOW_FREQ_OSC_ENABLE          6
`define CMRC_SYS2_SYSTEM_CLOCK_SELECT         5
`define CMRC_SYS2_TIMING_GENERATOR_HALT        2
`define CMRC_SYS2_RESET         8'hC0

`define CMRC_TBC_TIME_BASE_ENABLE          3
`define CMRC_TRAP_RAM_TRAP_SELECT          0
`define CMRC_TRAP_TOINT         1
`define CMRC_TRAP_SFRON         2
`define CMRC_TRAP_RESET         8'h05

`define CMRC_RESET_VECTOR       16'hFFFE
`define CMRC_SFR_LAST           16'h003F
`define CMRC_RAM_FIRST          16'h0040
`define CMRC_RAM_LAST           16'h013F

`endif

// file: cmrc_sync.v
/*
 Two-flop synchroniser for single-bit levels.
 Assumes the input is asynchronous to CLK_IN.
*/
`timescale 1ns/1ps
module cmrc_sync
(
  input  wire clk_in,
  input  wire resetn_in,
  input  wire rst_val_in,
  input  wire d_in,
  output reg  q_out
);

  reg meta_q;

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_q <= 1'b0;
      q_out  <= 1'b0;
    end
    else
    begin
      meta_q <= d_in ^ rst_val_in;
      q_out  <= meta_q;
    end
  end

endmodule

// file: cmrc_properties.sv
/*
 Port assertions for the clock mode and reset controller.
 Assumes it is bound to cmrc_top, with APB on CLK_IN.
*/
`timescale 1ns/1ps
module cmrc_properties
(
  input logic        CLK_IN,
  input logic        RESETN_IN,
  input logic        PSEL_IN,
  input logic        PENABLE_IN,
  input logic        PWRITE_IN,
  input logic [11:0] PADDR_IN,
  input logic [31:0] PWDATA_IN,
  input logic        PREADY_OUT,
  input logic        RST_PIN_N_IN,
  input logic        WDT_IRQ_IN,
  input logic        SYS_RESET_N_OUT,
  input logic [15:0] START_VECTOR_OUT,
  input logic        HF_OSC_EN_OUT,
  input logic        CLK_SEL_SLOW_OUT,
  input logic        IDLE_GATED_OUT,
  input logic        TBT_IRQ_START_OUT,
  input logic        PRESCALER_CLR_OUT,
  input logic        WDT_ENABLE_OUT
);
  // Writes during reset are dropped, so only count those seen out of reset
  wire wr0 = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT && PADDR_IN == 12'h000
    && SYS_RESET_N_OUT;
  wire [31:0] d = PWDATA_IN;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  AST_SLOW_SEL: assert property (wr0 && d[7] && d[6] && d[5] |-> ##[1:3] CLK_SEL_SLOW_OUT)
    else $error("slow clock not selected");
  AST_HF_STOP: assert property (wr0 && !d[7] && d[6] && d[5] |-> ##[1:3] !HF_OSC_EN_OUT)
    else $error("fast oscillator still on");
  AST_FAST_WAIT: assert property (wr0 && d[7] && d[6] && !d[5] && CLK_SEL_SLOW_OUT
    |=> CLK_SEL_SLOW_OUT [*2])
    else $error("fast clock taken before sync");
  AST_CLK_RST: assert property (wr0 && (d[7:6] == 2'b00 || !d[7] && !d[5] || !d[6] && d[5])
    |-> ##[1:3] !SYS_RESET_N_OUT)
    else $error("no clock reset");
  AST_RST_LEN: assert property ($fell(SYS_RESET_N_OUT) && RST_PIN_N_IN
    |-> ##[1:300] SYS_RESET_N_OUT)
    else $error("malfunction reset too long");
  AST_PWR_UP: assert property ($rose(RESETN_IN) |-> ##[1:300] SYS_RESET_N_OUT)
    else $error("power-up reset too long");
  AST_WDT_IDLE: assert property (wr0 && d[2] && WDT_IRQ_IN |=> !IDLE_GATED_OUT [*3])
    else $error("idle entered with watchdog interrupt");
  AST_TBT_WAKE: assert property ($rose(TBT_IRQ_START_OUT)
    |-> ($past(IDLE_GATED_OUT) || $past(IDLE_GATED_OUT, 2)) ##1 !TBT_IRQ_START_OUT)
    else $error("interrupt start without idle wake");
  AST_RST_STATE: assert property (!SYS_RESET_N_OUT && !$past(SYS_RESET_N_OUT)
    |-> PRESCALER_CLR_OUT && WDT_ENABLE_OUT)
    else $error("prescaler or watchdog wrong in reset");
  AST_RST_FAST: assert property ($rose(SYS_RESET_N_OUT)
    |-> !CLK_SEL_SLOW_OUT && START_VECTOR_OUT == 16'hFFFE)
    else $error("wrong mode or vector after reset");
endmodule

bind cmrc_top cmrc_properties u_props (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT), .RST_PIN_N_IN(RST_PIN_N_IN),
  .WDT_IRQ_IN(WDT_IRQ_IN), .SYS_RESET_N_OUT(SYS_RESET_N_OUT),
  .START_VECTOR_OUT(START_VECTOR_OUT), .HF_OSC_EN_OUT(HF_OSC_EN_OUT),
  .CLK_SEL_SLOW_OUT(CLK_SEL_SLOW_OUT), .IDLE_GATED_OUT(IDLE_GATED_OUT),
  .TBT_IRQ_START_OUT(TBT_IRQ_START_OUT), .PRESCALER_CLR_OUT(PRESCALER_CLR_OUT),
  .WDT_ENABLE_OUT(WDT_ENABLE_OUT));

// file: cmrc_pin_model.sv
/*
 External reset pin driver and time-base source.
 Assumes a free-running clk_in for pacing only.
*/
`timescale 1ns/1ps
module cmrc_pin_model
(
  input  logic clk_in,
  output logic rst_pin_n_out,
  output logic tb_src_out
);
  initial
  begin
    rst_pin_n_out = 1'b1;
    tb_src_out = 1'b1;
  end
  // Callers pass at least twelve fast periods, else the reset may be missed
  task hold_low(input int n);
    @(posedge clk_in);
    rst_pin_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    rst_pin_n_out <= 1'b1;
  endtask
  // One falling edge, held long enough to pass the synchroniser
  task tick;
    @(posedge clk_in);
    tb_src_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    tb_src_out <= 1'b1;
  endtask
endmodule

// file: clock_mode_and_reset_control_test.sv
/*
 Self-checking bench for the clock mode and reset controller.
 Assumes cmrc_top, the pin model and the bound checker.
*/
`timescale 1ns/1ps
module clock_mode_and_reset_control_test;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        wirq = 1'b0;
  logic        wrst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          checks_done = 0;
  int          n_tbt = 0;
  int          n_trap = 0;
  int          k;
  logic [7:0]  bad [3] = '{8'h00, 8'h40, 8'hA0};
  wire  [31:0] prdata;
  wire  [15:0] vec;
  wire         pready, pslverr, pin_n, src, srst_n, hf, lf, slow, idle, tbt, trap, pclr, wen;

  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    n_tbt <= n_tbt + (tbt === 1'b1);
    n_trap <= n_trap + (trap === 1'b1);
  end
  cmrc_pin_model pin (.clk_in(clk), .rst_pin_n_out(pin_n), .tb_src_out(src));
  cmrc_top DUT (.CLK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RST_PIN_N_IN(pin_n), .TB_SRC_IN(src),
    .WDT_IRQ_IN(wirq), .WDT_RST_REQ_IN(wrst), .SYS_RESET_N_OUT(srst_n),
    .START_VECTOR_OUT(vec), .HF_OSC_EN_OUT(hf), .LF_OSC_EN_OUT(lf), .CLK_SEL_SLOW_OUT(slow),
    .IDLE_GATED_OUT(idle), .TBT_IRQ_START_OUT(tbt), .TRAP_IRQ_OUT(trap),
    .PRESCALER_CLR_OUT(pclr), .WDT_ENABLE_OUT(wen));

  task summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task timeout;
    num_errors++;
    $display("ERROR %0t wait ran out", $time);
    summarize();
  endtask
  // Read data and the error flag are taken only at the ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge clk);
    if (i == 20)
      timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wait_rst(input logic lvl);
    int i;
    for (i = 0; i < 400 && srst_n !== lvl; i++)
      @(posedge clk);
    if (i == 400)
      timeout();
    chk(srst_n, lvl);
  endtask

  task t_regs;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_00C0);
    apb(0, 12'h008, 0);
    chk(rd, 32'h0000_0000);
    apb(0, 12'h00C, 0);
    chk(rd, 32'h0000_0005);
    chk(wen, 1'b1);
    chk(vec, 16'hFFFE);
    apb(0, 12'h020, 0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
  endtask
  task t_slow;
    apb(1, 12'h000, 8'hE0);
    repeat (3) @(posedge clk);
    chk(slow, 1'b1);
    apb(1, 12'h000, 8'h60);
    repeat (3) @(posedge clk);
    chk(hf, 1'b0);
    chk(srst_n, 1'b1);
    apb(1, 12'h000, 8'hE0);
    repeat (50) @(posedge clk);
    apb(1, 12'h000, 8'hC0);
    chk(slow, 1'b1);
    repeat (8) @(posedge clk);
    chk(slow, 1'b0);
  endtask
  task t_clkrst;
    for (int j = 0; j < 3; j++)
    begin
      apb(1, 12'h000, bad[j]);
      wait_rst(1'b0);
      chk(pclr, 1'b1);
      chk(hf, 1'b1);
      chk(lf, 1'b1);
      wait_rst(1'b1);
      apb(0, 12'h000, 0);
      chk(rd, 32'h0000_00C0);
    end
  endtask
  // Wake first with the interrupt fully enabled, then with the master enable off
  task t_idle;
    apb(1, 12'h004, 8'h08);
    for (int j = 0; j < 2; j++)
    begin
      apb(1, 12'h008, j ? 8'h02 : 8'h03);
      k = n_tbt;
      apb(1, 12'h000, 8'hC4);
      repeat (3) @(posedge clk);
      chk(idle, 1'b1);
      pin.tick();
      repeat (10) @(posedge clk);
      chk(idle, 1'b0);
      chk(n_tbt - k, j ? 0 : 1);
      apb(0, 12'h000, 0);
      chk(rd, 32'h0000_00C0);
    end
    wirq <= 1'b1;
    apb(1, 12'h000, 8'hC4);
    repeat (3) @(posedge clk);
    chk(idle, 1'b0);
    apb(1, 12'h000, 8'hC0);
    wirq <= 1'b0;
  endtask
  task t_trap;
    apb(1, 12'h00C, 8'h07);
    k = n_trap;
    apb(1, 12'h014, 16'h0050);
    repeat (4) @(posedge clk);
    chk(n_trap - k, 1);
    chk(srst_n, 1'b1);
    apb(0, 12'h018, 0);
    chk(rd, 32'h0000_0007);
    apb(1, 12'h018, 32'h0000_0007);
    apb(0, 12'h018, 0);
    chk(rd, 32'h0000_0000);
    apb(1, 12'h00C, 8'h06);
    k = n_trap;
    apb(1, 12'h014, 16'h0050);
    repeat (4) @(posedge clk);
    chk(n_trap - k, 0);
    apb(1, 12'h00C, 8'h05);
    apb(1, 12'h014, 16'h0010);
    wait_rst(1'b0);
    wait_rst(1'b1);
    wrst <= 1'b1;
    @(posedge clk);
    wrst <= 1'b0;
    wait_rst(1'b0);
    wait_rst(1'b1);
  endtask
  task t_pin;
    apb(1, 12'h000, 8'hE0);
    pin.hold_low(160);
    chk(srst_n, 1'b0);
    wait_rst(1'b1);
    chk(slow, 1'b0);
    chk(vec, 16'hFFFE);
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_00C0);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    wait_rst(1'b1);
    t_regs();
    t_slow();
    t_clkrst();
    t_idle();
    t_trap();
    t_pin();
    summarize();
  end
endmodule
